/* File: dv/rssalu_mem_model.sv */
// operand memory cell model on the far side of the datapath
`timescale 1ns/100ps
module rssalu_mem_model
	import rssalu_pkg::*;
(
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	// preload from the sequencer side
	input  wire logic                 load_en,
	input  wire logic [RSSALU_DW-1:0] load_val,
	// write-back from the datapath
	input  wire logic                 mem_we,
	input  wire logic [RSSALU_DW-1:0] mem_wdata,
	// operand byte
	output logic      [RSSALU_DW-1:0] mem_rdata
);
	// write-back wins over a preload in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mem_rdata <= 8'h00;
		else if (mem_we)
			mem_rdata <= mem_wdata;
		else if (load_en)
			mem_rdata <= load_val;
	end
endmodule

/* File: dv/tb.sv */
// self-checking bench for the rotate/subtract/skip datapath
`timescale 1ns/100ps
module tb
	import rssalu_pkg::*;
;
	logic       sys_clk, rst_n, op_valid, load_en, mem_we, busy, discard_fetch;
	logic       carry_flag, half_carry_flag, zero_flag, twos_complement_wrap_flag;
	logic [4:0] op_code;
	logic [2:0] bit_sel;
	logic [7:0] imm_data, mem_rdata, mem_wdata, acc, load_val, ea;
	logic [3:0] ef;
	int         bad_count, tests_run;

	rssalu_core #(.DW(RSSALU_DW)) i_rssalu_core (.sys_clk(sys_clk), .rst_n(rst_n),
		.op_valid(op_valid), .op_code(op_code), .bit_sel(bit_sel), .imm_data(imm_data),
		.mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .acc(acc),
		.carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
		.twos_complement_wrap_flag(twos_complement_wrap_flag),
		.discard_fetch(discard_fetch), .busy(busy));
	rssalu_mem_model i_rssalu_mem_model (.sys_clk(sys_clk), .rst_n(rst_n), .load_en(load_en),
		.load_val(load_val), .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

	////////////////////////////////////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic chk_bit(input logic exp, input logic got);
		chk_byte({7'h00, exp}, {7'h00, got});
	endtask

	task automatic finish_test();
		$display("%0d compares, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one instruction against a reference; poke offers an op in the dummy cycle
	task automatic run(input rssalu_op_e op, input logic [7:0] m, input logic [2:0] bs,
		input logic [7:0] imm, input logic poke);
		logic [7:0] r, b, em;
		logic [8:0] s;
		logic [4:0] h;
		logic [3:0] nf;
		logic       skip, wr, cin, to_acc;
		r = ea;
		em = m;
		nf = ef;
		skip = 1'b0;
		b = (op == RSSALU_MINUS_IMM_TO_ACC) ? imm : m;
		cin = (op inside {RSSALU_MINUS_WITH_BORROW_TO_ACC, RSSALU_MINUS_WITH_BORROW_TO_MEM})
			? ef[RSSALU_F_C] : 1'b1;
		s = {1'b0, ea} + {1'b0, ~b} + {8'h00, cin};
		h = {1'b0, ea[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
		case (op)
			RSSALU_ROTATE_LEFT_VIA_CARRY, RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC:
			begin
				r = {m[6:0], ef[RSSALU_F_C]};
				nf[RSSALU_F_C] = m[7];
			end
			RSSALU_ROTATE_RIGHT_BYTE, RSSALU_ROTATE_RIGHT_TO_ACC: r = {m[0], m[7:1]};
			RSSALU_ROTATE_RIGHT_VIA_CARRY, RSSALU_ROTATE_RIGHT_VIA_CARRY_TO_ACC:
			begin
				r = {ef[RSSALU_F_C], m[7:1]};
				nf[RSSALU_F_C] = m[0];
			end
			RSSALU_MINUS_WITH_BORROW_TO_ACC, RSSALU_MINUS_WITH_BORROW_TO_MEM,
			RSSALU_MINUS_TO_ACC, RSSALU_MINUS_TO_MEM, RSSALU_MINUS_IMM_TO_ACC:
			begin
				r = s[7:0];
				nf = {(ea[7] != b[7]) && (s[7] != ea[7]), s[7:0] == 8'h00, h[4], s[8]};
			end
			RSSALU_DECREMENT_SKIP_ZERO, RSSALU_DECREMENT_SKIP_ZERO_TO_ACC: r = m - 8'h01;
			RSSALU_INCREMENT_SKIP_ZERO, RSSALU_INCREMENT_SKIP_ZERO_TO_ACC: r = m + 8'h01;
			RSSALU_FILL_BYTE: r = 8'hFF;
			RSSALU_SET_BIT: r = m | (8'h01 << bs);
			RSSALU_SKIP_BIT_NONZERO: skip = m[bs];
			default: r = {m[3:0], m[7:4]};
		endcase
		if (op inside {RSSALU_DECREMENT_SKIP_ZERO, RSSALU_DECREMENT_SKIP_ZERO_TO_ACC,
			RSSALU_INCREMENT_SKIP_ZERO, RSSALU_INCREMENT_SKIP_ZERO_TO_ACC})
			skip = (r == 8'h00);
		to_acc = op inside {RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC, RSSALU_ROTATE_RIGHT_TO_ACC,
			RSSALU_ROTATE_RIGHT_VIA_CARRY_TO_ACC, RSSALU_MINUS_WITH_BORROW_TO_ACC,
			RSSALU_MINUS_TO_ACC, RSSALU_MINUS_IMM_TO_ACC, RSSALU_DECREMENT_SKIP_ZERO_TO_ACC,
			RSSALU_INCREMENT_SKIP_ZERO_TO_ACC, RSSALU_NIBBLE_EXCHANGE_TO_ACC};
		wr = !to_acc && op != RSSALU_SKIP_BIT_NONZERO;
		if (to_acc)
			ea = r;
		if (wr)
			em = r;
		@(negedge sys_clk);
		load_en = 1'b1;
		load_val = m;
		@(negedge sys_clk);
		load_en = 1'b0;
		op_valid = 1'b1;
		op_code = op;
		bit_sel = bs;
		imm_data = imm;
		@(negedge sys_clk);
		op_valid = poke & skip;
		op_code = RSSALU_FILL_BYTE;
		chk_byte(ea, acc);
		chk_byte({4'h0, nf}, {4'h0, twos_complement_wrap_flag, zero_flag, half_carry_flag,
			carry_flag});
		chk_bit(wr, mem_we);
		chk_bit(skip, discard_fetch);
		chk_bit(skip, busy);
		chk_byte(8'(skip ? RSSALU_SKIP_CYC : RSSALU_PLAIN_CYC), {7'h00, busy} + 8'h01);
		if (wr)
			chk_byte(r, mem_wdata);
		@(negedge sys_clk);
		op_valid = 1'b0;
		chk_bit(1'b0, mem_we);
		chk_bit(1'b0, busy);
		chk_byte(em, mem_rdata);
		ef = nf;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_subtract();
		run(RSSALU_MINUS_IMM_TO_ACC, 8'h00, 3'h0, 8'h80, 1'b0);
		run(RSSALU_MINUS_TO_ACC, 8'h01, 3'h0, 8'h00, 1'b0);
		run(RSSALU_MINUS_WITH_BORROW_TO_ACC, 8'h7F, 3'h0, 8'h00, 1'b0);
		run(RSSALU_MINUS_TO_MEM, 8'h01, 3'h0, 8'h00, 1'b0);
		run(RSSALU_MINUS_WITH_BORROW_TO_MEM, 8'h00, 3'h0, 8'h00, 1'b0);
		run(RSSALU_MINUS_WITH_BORROW_TO_ACC, 8'h00, 3'h0, 8'h00, 1'b0);
		run(RSSALU_MINUS_TO_ACC, 8'hFF, 3'h0, 8'h00, 1'b0);
		$display("test subtract done");
	endtask

	task automatic t_rotate();
		run(RSSALU_ROTATE_LEFT_VIA_CARRY, 8'h80, 3'h0, 8'h00, 1'b0);
		run(RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC, 8'h41, 3'h0, 8'h00, 1'b0);
		run(RSSALU_ROTATE_RIGHT_BYTE, 8'h01, 3'h0, 8'h00, 1'b0);
		run(RSSALU_ROTATE_RIGHT_TO_ACC, 8'h03, 3'h0, 8'h00, 1'b0);
		run(RSSALU_ROTATE_RIGHT_VIA_CARRY, 8'h01, 3'h0, 8'h00, 1'b0);
		run(RSSALU_ROTATE_RIGHT_VIA_CARRY_TO_ACC, 8'h82, 3'h0, 8'h00, 1'b0);
		$display("test rotate done");
	endtask

	task automatic t_skip();
		run(RSSALU_DECREMENT_SKIP_ZERO, 8'h01, 3'h0, 8'h00, 1'b1);
		run(RSSALU_DECREMENT_SKIP_ZERO, 8'h00, 3'h0, 8'h00, 1'b0);
		run(RSSALU_DECREMENT_SKIP_ZERO_TO_ACC, 8'h01, 3'h0, 8'h00, 1'b0);
		run(RSSALU_DECREMENT_SKIP_ZERO_TO_ACC, 8'h05, 3'h0, 8'h00, 1'b0);
		run(RSSALU_INCREMENT_SKIP_ZERO, 8'hFF, 3'h0, 8'h00, 1'b1);
		run(RSSALU_INCREMENT_SKIP_ZERO, 8'h7F, 3'h0, 8'h00, 1'b0);
		run(RSSALU_INCREMENT_SKIP_ZERO_TO_ACC, 8'hFF, 3'h0, 8'h00, 1'b0);
		run(RSSALU_INCREMENT_SKIP_ZERO_TO_ACC, 8'h00, 3'h0, 8'h00, 1'b0);
		run(RSSALU_SKIP_BIT_NONZERO, 8'h80, 3'h7, 8'h00, 1'b1);
		run(RSSALU_SKIP_BIT_NONZERO, 8'h7F, 3'h7, 8'h00, 1'b0);
		run(RSSALU_SKIP_BIT_NONZERO, 8'h01, 3'h0, 8'h00, 1'b0);
		$display("test skip done");
	endtask

	task automatic t_set_swap();
		run(RSSALU_FILL_BYTE, 8'h00, 3'h0, 8'h00, 1'b0);
		run(RSSALU_SET_BIT, 8'h00, 3'h5, 8'h00, 1'b0);
		run(RSSALU_SET_BIT, 8'hFE, 3'h0, 8'h00, 1'b0);
		run(RSSALU_NIBBLE_EXCHANGE, 8'hA5, 3'h0, 8'h00, 1'b0);
		run(RSSALU_NIBBLE_EXCHANGE_TO_ACC, 8'h3C, 3'h0, 8'h00, 1'b0);
		$display("test set_swap done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	initial
	begin
		#100000;
		bad_count++;
		finish_test();
	end

	initial
	begin
		{rst_n, op_valid, load_en, op_code, bit_sel, imm_data, load_val} = '0;
		bad_count = 0;
		tests_run = 0;
		ea = RSSALU_ACC_RST;
		ef = RSSALU_FLAG_RST;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_n = 1'b1;
		chk_byte(ea, acc);
		chk_bit(1'b0, busy);
		$display("test reset done");
		t_subtract();
		t_rotate();
		t_skip();
		t_set_swap();
		finish_test();
	end
endmodule

/* File: rtl/rssalu_core.sv */
// rotate / subtract / skip / set / swap execution datapath
`timescale 1ns/100ps
// Function
// - memory rotate left through carry; bit0 from old carry, carry from bit7
// - same rotation into accumulator, carry from bit7, memory untouched
// - memory rotate right, bit0 into bit7, no flag change
// - rotate right into accumulator, memory kept, no flag change
// - memory rotate right through carry; bit7 from carry, carry from bit0
// - same rotation into accumulator, carry from bit0, memory untouched
// - acc plus inverted memory plus carry into acc, four flags updated
// - acc plus inverted memory plus carry into memory, four flags updated
// - acc plus inverted memory plus one into acc, four flags updated
// - acc plus inverted memory plus one into memory, four flags updated
// - acc plus inverted immediate plus one into acc, four flags updated
// - decrement memory, write back, skip with dummy cycle on zero
// - memory minus one into acc, skip with dummy cycle on zero
// - write all ones into memory byte, flags untouched
// - set selected memory bit, others kept, flags untouched
// - increment memory, write back, skip with dummy cycle on zero
// - memory plus one into acc, skip with dummy cycle on zero
// - skip with dummy cycle when selected memory bit is one
// - swap memory nibbles, write back, flags untouched
// - swapped nibbles go to accumulator instead of memory
module rssalu_core
	import rssalu_pkg::*;
#(
	parameter int DW = RSSALU_DW
)(
	// clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	// instruction from sequencer
	input  wire logic            op_valid,
	input  wire logic [4:0]      op_code,
	input  wire logic [2:0]      bit_sel,
	input  wire logic [DW-1:0]   imm_data,
	// memory operand
	input  wire logic [DW-1:0]   mem_rdata,
	// memory write-back
	output logic                 mem_we,
	output logic      [DW-1:0]   mem_wdata,
	// architectural state
	output logic      [DW-1:0]   acc,
	output logic                 carry_flag,
	output logic                 half_carry_flag,
	output logic                 zero_flag,
	output logic                 twos_complement_wrap_flag,
	// sequencing
	output logic                 discard_fetch,
	output logic                 busy
);
	rssalu_op_e    op;
	rssalu_state_e state_r;
	rssalu_state_e state_nxt;

	logic [DW-1:0] acc_r;
	logic [DW-1:0] acc_nxt;
	logic [3:0]    flags_r;
	logic [3:0]    flags_nxt;
	logic          mem_we_r;
	logic          mem_we_nxt;
	logic [DW-1:0] mem_wdata_r;
	logic [DW-1:0] mem_wdata_nxt;
	logic          discard_r;
	logic          skip_nxt;

	logic [DW-1:0] sub_b;
	logic          sub_cin;
	logic [DW-1:0] sub_res;
	logic          sub_c;
	logic          sub_hc;
	logic          sub_wrap;
	logic          step_down;
	logic [DW-1:0] step_res;
	logic          step_zero;
	logic [DW-1:0] swapped;
	logic [DW-1:0] bit_mask;
	logic          in_dummy;

	assign op = rssalu_op_e'(op_code);
	assign in_dummy = (state_r == RSSALU_ST_DUMMY);

	////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	always_comb
	begin
		sub_b = mem_rdata;
		sub_cin = 1'b1;
		case (op)
			RSSALU_MINUS_WITH_BORROW_TO_ACC,
			RSSALU_MINUS_WITH_BORROW_TO_MEM: sub_cin = flags_r[RSSALU_F_C];
			RSSALU_MINUS_IMM_TO_ACC: sub_b = imm_data;
			default: sub_cin = 1'b1;
		endcase
	end

	rssalu_sub #(.DW(DW)) u_sub (
		.a          (acc_r),
		.b          (sub_b),
		.cin        (sub_cin),
		.res        (sub_res),
		.carry      (sub_c),
		.half_carry (sub_hc),
		.wrap       (sub_wrap)
	);

	assign step_down = (op == RSSALU_DECREMENT_SKIP_ZERO) ||
	                   (op == RSSALU_DECREMENT_SKIP_ZERO_TO_ACC);

	rssalu_step #(.DW(DW)) u_step (
		.val     (mem_rdata),
		.down    (step_down),
		.res     (step_res),
		.is_zero (step_zero)
	);

	assign swapped = {mem_rdata[3:0], mem_rdata[DW-1:4]};
	assign bit_mask = DW'(1) << bit_sel;

	////////////////////////////////////////////////////////////////////
	// per-instruction next values

	always_comb
	begin
		acc_nxt = acc_r;
		flags_nxt = flags_r;
		mem_we_nxt = 1'b0;
		mem_wdata_nxt = mem_wdata_r;
		skip_nxt = 1'b0;
		// dummy cycle executes nothing
		if (op_valid && !in_dummy)
		begin
			case (op)
				RSSALU_ROTATE_LEFT_VIA_CARRY:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = {mem_rdata[DW-2:0], flags_r[RSSALU_F_C]};
					flags_nxt[RSSALU_F_C] = mem_rdata[DW-1];
				end
				RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC:
				begin
					acc_nxt = {mem_rdata[DW-2:0], flags_r[RSSALU_F_C]};
					flags_nxt[RSSALU_F_C] = mem_rdata[DW-1];
				end
				RSSALU_ROTATE_RIGHT_BYTE:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = {mem_rdata[0], mem_rdata[DW-1:1]};
				end
				RSSALU_ROTATE_RIGHT_TO_ACC:
					acc_nxt = {mem_rdata[0], mem_rdata[DW-1:1]};
				RSSALU_ROTATE_RIGHT_VIA_CARRY:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = {flags_r[RSSALU_F_C], mem_rdata[DW-1:1]};
					flags_nxt[RSSALU_F_C] = mem_rdata[0];
				end
				RSSALU_ROTATE_RIGHT_VIA_CARRY_TO_ACC:
				begin
					acc_nxt = {flags_r[RSSALU_F_C], mem_rdata[DW-1:1]};
					flags_nxt[RSSALU_F_C] = mem_rdata[0];
				end
				RSSALU_MINUS_WITH_BORROW_TO_ACC,
				RSSALU_MINUS_TO_ACC,
				RSSALU_MINUS_IMM_TO_ACC:
				begin
					acc_nxt = sub_res;
					flags_nxt = {sub_wrap, (sub_res == '0), sub_hc, sub_c};
				end
				RSSALU_MINUS_WITH_BORROW_TO_MEM,
				RSSALU_MINUS_TO_MEM:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = sub_res;
					flags_nxt = {sub_wrap, (sub_res == '0), sub_hc, sub_c};
				end
				RSSALU_DECREMENT_SKIP_ZERO,
				RSSALU_INCREMENT_SKIP_ZERO:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = step_res;
					skip_nxt = step_zero;
				end
				RSSALU_DECREMENT_SKIP_ZERO_TO_ACC,
				RSSALU_INCREMENT_SKIP_ZERO_TO_ACC:
				begin
					acc_nxt = step_res;
					skip_nxt = step_zero;
				end
				RSSALU_FILL_BYTE:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = RSSALU_ALL_ONES;
				end
				RSSALU_SET_BIT:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = mem_rdata | bit_mask;
				end
				RSSALU_SKIP_BIT_NONZERO:
					skip_nxt = |(mem_rdata & bit_mask);
				RSSALU_NIBBLE_EXCHANGE:
				begin
					mem_we_nxt = 1'b1;
					mem_wdata_nxt = swapped;
				end
				RSSALU_NIBBLE_EXCHANGE_TO_ACC:
					acc_nxt = swapped;
				default:
					acc_nxt = acc_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// skip sequencing: one dummy cycle after a taken skip

	always_comb
	begin
		case (state_r)
			RSSALU_ST_RUN: state_nxt = skip_nxt ? RSSALU_ST_DUMMY : RSSALU_ST_RUN;
			RSSALU_ST_DUMMY: state_nxt = RSSALU_ST_RUN;
			default: state_nxt = RSSALU_ST_RUN;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= RSSALU_ST_RUN;
			discard_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			discard_r <= skip_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// architectural registers

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_r <= RSSALU_ACC_RST;
			flags_r <= RSSALU_FLAG_RST;
		end
		else
		begin
			acc_r <= acc_nxt;
			flags_r <= flags_nxt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_we_r <= 1'b0;
			mem_wdata_r <= '0;
		end
		else
		begin
			mem_we_r <= mem_we_nxt;
			mem_wdata_r <= mem_wdata_nxt;
		end
	end

	assign mem_we = mem_we_r;
	assign mem_wdata = mem_wdata_r;
	assign acc = acc_r;
	assign carry_flag = flags_r[RSSALU_F_C];
	assign half_carry_flag = flags_r[RSSALU_F_HC];
	assign zero_flag = flags_r[RSSALU_F_Z];
	assign twos_complement_wrap_flag = flags_r[RSSALU_F_WRAP];
	assign discard_fetch = discard_r;
	assign busy = state_r[1]; // dummy-state bit of the one-hot register

	////////////////////////////////////////////////////////////////////
	// checks

	a_rotl_mem_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_ROTATE_LEFT_VIA_CARRY |=>
		mem_we && mem_wdata == {$past(mem_rdata[DW-2:0]), $past(flags_r[RSSALU_F_C])}
		&& carry_flag == $past(mem_rdata[DW-1]) && $stable(acc))
		else $error("rotate left via carry wrong");

	a_rotl_acc_result: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC |=>
		!mem_we && acc == {$past(mem_rdata[DW-2:0]), $past(flags_r[RSSALU_F_C])})
		else $error("rotate left to acc wrong");

	a_rotr_no_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_ROTATE_RIGHT_BYTE |=>
		mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[DW-1:1])} && $stable(flags_r))
		else $error("rotate right wrong");

	a_rotr_carry_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_ROTATE_RIGHT_VIA_CARRY |=>
		carry_flag == $past(mem_rdata[0]) && mem_wdata[DW-1] == $past(flags_r[RSSALU_F_C]))
		else $error("rotate right via carry wrong");

	a_sub_carry_borrow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_MINUS_TO_ACC |=>
		carry_flag == ($past(acc_r) >= $past(mem_rdata)) && acc == $past(acc_r - mem_rdata))
		else $error("subtract carry wrong");

	a_skip_dummy_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
		skip_nxt |=> discard_fetch && busy ##1 !busy)
		else $error("skip not exactly one dummy cycle");

	a_fill_ones: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_FILL_BYTE |=>
		mem_we && mem_wdata == RSSALU_ALL_ONES && $stable(flags_r))
		else $error("fill byte wrong");

	a_bit_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_SKIP_BIT_NONZERO |=>
		discard_fetch == $past(mem_rdata[bit_sel]) && !mem_we)
		else $error("bit skip wrong");

	a_swap_acc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		op_valid && !in_dummy && op == RSSALU_NIBBLE_EXCHANGE_TO_ACC |=>
		acc == {$past(mem_rdata[3:0]), $past(mem_rdata[DW-1:4])} && !mem_we)
		else $error("nibble swap to acc wrong");
endmodule

/* File: rtl/rssalu_pkg.sv */
// package: opcodes, flag positions and reset values for the rotate/subtract/skip datapath
package rssalu_pkg;
	localparam int RSSALU_DW = 8;
	localparam int RSSALU_OPW = 5;
	localparam logic [7:0] RSSALU_ALL_ONES = 8'hFF;
	localparam logic [7:0] RSSALU_ACC_RST = 8'h00;
	localparam logic [3:0] RSSALU_FLAG_RST = 4'h0;
	// flag vector positions
	localparam int RSSALU_F_C = 0;
	localparam int RSSALU_F_HC = 1;
	localparam int RSSALU_F_Z = 2;
	localparam int RSSALU_F_WRAP = 3;
	localparam int RSSALU_SKIP_CYC = 2;
	localparam int RSSALU_PLAIN_CYC = 1;

	typedef enum logic [4:0] {
		RSSALU_NOP                           = 5'h00,
		RSSALU_ROTATE_LEFT_VIA_CARRY         = 5'h01,
		RSSALU_ROTATE_LEFT_VIA_CARRY_TO_ACC  = 5'h02,
		RSSALU_ROTATE_RIGHT_BYTE             = 5'h03,
		RSSALU_ROTATE_RIGHT_TO_ACC           = 5'h04,
		RSSALU_ROTATE_RIGHT_VIA_CARRY        = 5'h05,
		RSSALU_ROTATE_RIGHT_VIA_CARRY_TO_ACC = 5'h06,
		RSSALU_MINUS_WITH_BORROW_TO_ACC      = 5'h07,
		RSSALU_MINUS_WITH_BORROW_TO_MEM      = 5'h08,
		RSSALU_MINUS_TO_ACC                  = 5'h09,
		RSSALU_MINUS_TO_MEM                  = 5'h0A,
		RSSALU_MINUS_IMM_TO_ACC              = 5'h0B,
		RSSALU_DECREMENT_SKIP_ZERO           = 5'h0C,
		RSSALU_DECREMENT_SKIP_ZERO_TO_ACC    = 5'h0D,
		RSSALU_FILL_BYTE                     = 5'h0E,
		RSSALU_SET_BIT                       = 5'h0F,
		RSSALU_INCREMENT_SKIP_ZERO           = 5'h10,
		RSSALU_INCREMENT_SKIP_ZERO_TO_ACC    = 5'h11,
		RSSALU_SKIP_BIT_NONZERO              = 5'h12,
		RSSALU_NIBBLE_EXCHANGE               = 5'h13,
		RSSALU_NIBBLE_EXCHANGE_TO_ACC        = 5'h14
	} rssalu_op_e;

	typedef enum logic [1:0] {
		RSSALU_ST_RUN   = 2'b01,
		RSSALU_ST_DUMMY = 2'b10
	} rssalu_state_e;
endpackage

/* File: rtl/rssalu_step.sv */
// plus/minus one with zero detect for the skip-on-zero family
`timescale 1ns/100ps
module rssalu_step
	import rssalu_pkg::*;
#(
	parameter int DW = RSSALU_DW
)(
	// operand and direction
	input  wire logic [DW-1:0] val,
	input  wire logic          down,
	// result
	output logic      [DW-1:0] res,
	output logic               is_zero
);
	always_comb
	begin
		res = down ? val - {{(DW-1){1'b0}}, 1'b1} : val + {{(DW-1){1'b0}}, 1'b1};
		is_zero = (res == '0);
	end
endmodule

/* File: rtl/rssalu_sub.sv */
// adder core for the difference family: a + ~b + cin with flags
`timescale 1ns/100ps
module rssalu_sub
	import rssalu_pkg::*;
#(
	parameter int DW = RSSALU_DW
)(
	// operands
	input  wire logic [DW-1:0] a,
	input  wire logic [DW-1:0] b,
	input  wire logic          cin,
	// result
	output logic      [DW-1:0] res,
	output logic               carry,
	output logic               half_carry,
	output logic               wrap
);
	logic [DW:0]  full;
	logic [4:0]   low;
	logic [DW-1:0] nb;

	always_comb
	begin
		nb = ~b;
		full = {1'b0, a} + {1'b0, nb} + {{DW{1'b0}}, cin};
		low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
		res = full[DW-1:0];
		carry = full[DW];
		half_carry = low[4];
		wrap = (a[DW-1] == nb[DW-1]) && (res[DW-1] != a[DW-1]);
	end
endmodule
